// File: rtl/lpcd_pkg.sv
// Shared constants, types and helpers for the LIN position command link
package lpcd_pkg;
    localparam int BYTE_W  = 8;
    localparam int POS_W   = 16;
    localparam int SPOS_W  = 11;
    localparam int ID_W    = 6;
    localparam int AD_W    = 7;
    localparam int SAD_W   = 4;
    localparam int PTR_W   = 4;
    localparam int CNT_W   = 4;
    localparam int MAX_DATA = 8;
    localparam int APB_AW  = 12;
    localparam int APB_DW  = 32;

    // Frame identifiers, command codes and field positions
    localparam logic [5:0] MREQ_ID      = 6'h3C;
    localparam logic [7:0] APP_CMD_BYTE = 8'h80;
    localparam logic [7:0] CMD_GOTO     = 8'h8B;   // Top bit set plus code 0x0B
    localparam logic [3:0] GP4_POINTER  = 4'h1;
    localparam int BROAD_BIT  = 7;
    localparam int SBROAD_BIT = 4;
    localparam int SFIX_BIT   = 4;
    localparam int SHI_LSB    = 5;
    localparam logic [3:0] LEN_2 = 4'h2;
    localparam logic [3:0] LEN_4 = 4'h4;
    localparam logic [3:0] LEN_8 = 4'h8;

    // Register map of the master end
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_ID      = 12'h004;
    localparam logic [11:0] REG_DATA_LO = 12'h008;
    localparam logic [11:0] REG_DATA_HI = 12'h00C;
    localparam logic [11:0] REG_STATUS  = 12'h010;
    localparam int CTRL_GO_BIT  = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CNT_LSB = 8;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ID   = 2'b01,
        TX_DATA = 2'b10,
        TX_SUM  = 2'b11
    } lpcd_tx_state_type;

    typedef enum logic {
        RX_IDLE = 1'b0,
        RX_DATA = 1'b1
    } lpcd_rx_state_type;

    // Identifier with its two parity bits on top
    function automatic logic [7:0] lpcd_protect(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id};
    endfunction

    // Data byte count implied by identifier bits 5:4
    function automatic logic [3:0] lpcd_frame_len(input logic [5:0] id);
        return id[5] ? (id[4] ? LEN_8 : LEN_4) : LEN_2;
    endfunction

    // Running sum with end-around carry; checksum is its inverse
    function automatic logic [7:0] lpcd_sum_add(input logic [7:0] s, input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        return t[7:0] + {7'h00, t[8]};
    endfunction
endpackage

// File: rtl/lpcd_link_if.sv
// Frame-level byte link between the bus master end and the motor node end
`timescale 1ns/1ps
interface lpcd_link_if;
    logic       byte_valid;   // One byte this cycle
    logic [7:0] byte_data;
    logic       byte_first;   // Byte is the protected identifier
    logic       byte_last;    // Byte is the checksum

    modport master (output byte_valid, output byte_data, output byte_first, output byte_last);
    modport node   (input  byte_valid, input  byte_data, input  byte_first, input  byte_last);
endinterface

// File: rtl/lpcd_node.sv
// Motor node end: decodes absolute and half-step position frames
// How it works
// - Direct form: high position byte, low, checksum
// - Master gives each motor its own direct identifier
// - Four-byte form only when pointer is 0001
// - Four-byte form: command, broadcast/address, position
// - Broadcast flag zero: every node takes target
// - Two-motor frame on 0x3C, app 0x80, 0x0B
// - Signed targets; apply only slot matching address
// - Drop full command when priority state forbids
// - Short target is 11-bit half-step value
// - Short commands match four low address bits
// - Hardwired address pins tied high for short use
// - Drop short command when priority state forbids
// - One-motor short: pos high, broadcast, address, low
// - Short broadcast zero: every node takes target
// - Two-motor short: ID 10, four bytes, fixed one
// - Four-motor short: ID 11, eight bytes
// - Multi-motor short: take matching address slot only
// - Short positions are signed 11-bit
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module lpcd_node
    import lpcd_pkg::*;
(
    input  wire logic                       clock_in,
    input  wire logic                       rstn_in,
    lpcd_link_if.node                       link,
    input  wire logic [lpcd_pkg::AD_W-1:0]  node_address_in,
    input  wire logic [lpcd_pkg::SAD_W-1:0] otp_node_address_bits_in,
    input  wire logic [lpcd_pkg::ID_W-1:0]  full_direct_id_in,
    input  wire logic [lpcd_pkg::ID_W-1:0]  gp4_id_in,
    input  wire logic [lpcd_pkg::PTR_W-1:0] gp4_pointer_in,
    input  wire logic [lpcd_pkg::ID_W-1:0]  short1_id_in,
    input  wire logic [lpcd_pkg::ID_W-1:0]  short2_id_in,
    input  wire logic [lpcd_pkg::ID_W-1:0]  short4_id_in,
    input  wire logic                       accept_allowed_in,
    input  wire logic [1:0]                 microstep_resolution_in,
    output logic                            target_valid_out,
    output logic [lpcd_pkg::POS_W-1:0]      target_pos_out,
    output logic                            target_halfstep_out,
    output logic [1:0]                      microstep_resolution_out,
    output logic                            frame_dropped_out,
    output logic                            cmd_refused_out
);
    import lpcd_pkg::*;

    lpcd_rx_state_type  state_reg;
    logic [7:0]         id_reg;
    logic [7:0]         data_reg [0:MAX_DATA-1];
    logic [CNT_W-1:0]   cnt_reg;
    logic [7:0]         sum_reg;
    logic               overrun_reg;

    // Decode results for the frame ending this cycle
    logic               hit;
    logic               is_short;
    logic [POS_W-1:0]   pos;
    logic               frame_ok;
    logic               end_now;
    logic [5:0]         id;
    logic [3:0]         nslots;

    assign id      = id_reg[ID_W-1:0];
    assign end_now = link.byte_valid && link.byte_last && (state_reg == RX_DATA);

    // Short slot address field matches the four low address bits
    function automatic logic short_match(input logic [7:0] hi,
                                         input logic [3:0] own);
        return hi[SAD_W-1:0] == own;
    endfunction

    // Sign-extend an 11-bit half-step target to the target width
    function automatic logic [POS_W-1:0] short_pos(input logic [7:0] hi,
                                                   input logic [7:0] lo);
        logic [SPOS_W-1:0] p;
        p = {hi[7:SHI_LSB], lo};
        return {{(POS_W - SPOS_W){p[SPOS_W-1]}}, p};
    endfunction

    // Frame receive state
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            state_reg <= RX_IDLE;
        end else if (link.byte_valid && link.byte_first) begin
            state_reg <= RX_DATA;
        end else if (link.byte_valid && link.byte_last) begin
            state_reg <= RX_IDLE;
        end
    end

    // Identifier capture
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            id_reg <= 8'h00;
        end else if (link.byte_valid && link.byte_first) begin
            id_reg <= link.byte_data;
        end
    end

    // Data byte count, running sum and overrun flag; a new identifier restarts all three
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            cnt_reg     <= '0;
            sum_reg     <= 8'h00;
            overrun_reg <= 1'b0;
        end else if (link.byte_valid && link.byte_first) begin
            cnt_reg     <= '0;
            sum_reg     <= 8'h00;
            overrun_reg <= 1'b0;
        end else if (link.byte_valid && !link.byte_last && state_reg == RX_DATA) begin
            if (cnt_reg == LEN_8) begin
                overrun_reg <= 1'b1;   // Longer than any frame: poison it
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
            sum_reg <= lpcd_sum_add(sum_reg, link.byte_data);
        end
    end

    // Byte storage, indexed by position in the frame
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < MAX_DATA; i++) begin
                data_reg[i] <= 8'h00;
            end
        end else if (link.byte_valid && !link.byte_first && !link.byte_last
                     && state_reg == RX_DATA && cnt_reg != LEN_8) begin
            data_reg[cnt_reg[2:0]] <= link.byte_data;
        end
    end

    // Integrity: parity, length and checksum all right
    assign frame_ok = (id_reg == lpcd_protect(id))
                   && (cnt_reg == lpcd_frame_len(id)) && !overrun_reg
                   && (link.byte_data == ~sum_reg);

    // Command decode over the stored bytes
    always_comb begin
        hit      = 1'b0;
        is_short = 1'b0;
        pos      = '0;
        nslots   = cnt_reg >> 1;
        if (id == MREQ_ID) begin
            if (data_reg[0] == APP_CMD_BYTE && data_reg[1] == CMD_GOTO) begin
                if (data_reg[2][AD_W-1:0] == node_address_in) begin
                    hit = 1'b1;
                    pos = {data_reg[3], data_reg[4]};
                end else if (data_reg[5][AD_W-1:0] == node_address_in) begin
                    hit = 1'b1;
                    pos = {data_reg[6], data_reg[7]};
                end
            end
        end else if (id == full_direct_id_in) begin
            hit = 1'b1;
            pos = {data_reg[0], data_reg[1]};
        end else if (id == gp4_id_in) begin
            if (gp4_pointer_in == GP4_POINTER && data_reg[0] == CMD_GOTO
                && (!data_reg[1][BROAD_BIT]
                    || data_reg[1][AD_W-1:0] == node_address_in)) begin
                hit = 1'b1;
                pos = {data_reg[2], data_reg[3]};
            end
        end else if (id == short1_id_in) begin
            if (!data_reg[0][SBROAD_BIT]
                || short_match(data_reg[0], otp_node_address_bits_in)) begin
                hit      = 1'b1;
                is_short = 1'b1;
                pos      = short_pos(data_reg[0], data_reg[1]);
            end
        end else if (id == short2_id_in || id == short4_id_in) begin
            for (int k = MAX_DATA / 2 - 1; k >= 0; k--) begin
                if (k < int'(nslots) && !hit && data_reg[2*k][SFIX_BIT]
                    && short_match(data_reg[2*k], otp_node_address_bits_in)) begin
                    hit      = 1'b1;
                    is_short = 1'b1;
                    pos      = short_pos(data_reg[2*k], data_reg[2*k+1]);
                end
            end
        end
    end

    // Target output; stays put unless a good, permitted command lands
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            target_valid_out    <= 1'b0;
            target_pos_out      <= '0;
            target_halfstep_out <= 1'b0;
        end else begin
            target_valid_out <= end_now && frame_ok && hit && accept_allowed_in;
            if (end_now && frame_ok && hit && accept_allowed_in) begin
                target_pos_out      <= pos;
                target_halfstep_out <= is_short;
            end
        end
    end

    // Step mode carried alongside so motion keeps its resolution
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            microstep_resolution_out <= 2'b00;
        end else begin
            microstep_resolution_out <= microstep_resolution_in;
        end
    end

    // Event pulses for dropped frames and refused commands
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            frame_dropped_out <= 1'b0;
            cmd_refused_out   <= 1'b0;
        end else begin
            frame_dropped_out <= end_now && !frame_ok;
            cmd_refused_out   <= end_now && frame_ok && hit && !accept_allowed_in;
        end
    end
endmodule // lpcd_node

// File: rtl/lpcd_master.sv
// Bus master end: software builds a frame over APB and it is sent on the link
`timescale 1ns/1ps
module lpcd_master
    import lpcd_pkg::*;
(
    input  wire logic                        clock_in,
    input  wire logic                        rstn_in,
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [lpcd_pkg::APB_AW-1:0] paddr_in,
    input  wire logic [lpcd_pkg::APB_DW-1:0] pwdata_in,
    output logic      [lpcd_pkg::APB_DW-1:0] prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    lpcd_link_if.master                      link,
    output logic                             hardwired_address_pin_0_out,
    output logic                             hardwired_address_pin_1_out,
    output logic                             hardwired_address_pin_2_out
);
    import lpcd_pkg::*;

    lpcd_tx_state_type  state_reg;
    logic [ID_W-1:0]    id_reg;
    logic [31:0]        data_lo_reg;
    logic [31:0]        data_hi_reg;
    logic [CNT_W-1:0]   idx_reg;
    logic [CNT_W-1:0]   len_reg;
    logic [7:0]         sum_reg;
    logic [7:0]         frames_reg;
    logic               mapped;
    logic               wr_now;
    logic [63:0]        payload;
    logic [7:0]         cur_byte;

    assign mapped   = paddr_in == REG_CTRL || paddr_in == REG_ID || paddr_in == REG_DATA_LO
                   || paddr_in == REG_DATA_HI || paddr_in == REG_STATUS;
    assign wr_now   = psel_in && penable_in && pready_out && pwrite_in && mapped;
    assign payload  = {data_hi_reg, data_lo_reg};
    assign cur_byte = payload[{idx_reg[2:0], 3'b000} +: 8];

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end else begin
            pready_out  <= psel_in && penable_in && !pready_out;
            pslverr_out <= psel_in && penable_in && !pready_out && !mapped;
            prdata_out  <= '0;
            if (psel_in && penable_in && !pready_out && !pwrite_in) begin
                case (paddr_in)
                    REG_ID:      prdata_out <= {26'h0000000, id_reg};
                    REG_DATA_LO: prdata_out <= data_lo_reg;
                    REG_DATA_HI: prdata_out <= data_hi_reg;
                    REG_STATUS:  prdata_out <= {16'h0000, frames_reg, 7'h00,
                                                state_reg != TX_IDLE};
                    default:     prdata_out <= '0;
                endcase
            end
        end
    end

    // Frame setup registers; writes while busy are ignored
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            id_reg      <= '0;
            data_lo_reg <= '0;
            data_hi_reg <= '0;
        end else if (wr_now && state_reg == TX_IDLE) begin
            if (paddr_in == REG_ID) id_reg <= pwdata_in[ID_W-1:0];
            if (paddr_in == REG_DATA_LO) data_lo_reg <= pwdata_in;
            if (paddr_in == REG_DATA_HI) data_hi_reg <= pwdata_in;
        end
    end

    // Transmit sequencer: identifier, data bytes, checksum
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            state_reg <= TX_IDLE;
            idx_reg   <= '0;
            len_reg   <= LEN_2;
            sum_reg   <= 8'h00;
        end else begin
            case (state_reg)
                TX_IDLE: begin
                    if (wr_now && paddr_in == REG_CTRL && pwdata_in[CTRL_GO_BIT]) begin
                        state_reg <= TX_ID;
                        len_reg   <= lpcd_frame_len(id_reg);
                    end
                end
                TX_ID: begin
                    state_reg <= TX_DATA;
                    idx_reg   <= '0;
                    sum_reg   <= 8'h00;
                end
                TX_DATA: begin
                    sum_reg <= lpcd_sum_add(sum_reg, cur_byte);
                    idx_reg <= idx_reg + 4'h1;
                    if (idx_reg == len_reg - 4'h1) state_reg <= TX_SUM;
                end
                TX_SUM:  state_reg <= TX_IDLE;
                default: state_reg <= TX_IDLE;
            endcase
        end
    end

    // Link outputs, registered one cycle behind the sequencer
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            link.byte_valid <= 1'b0;
            link.byte_first <= 1'b0;
            link.byte_last  <= 1'b0;
            link.byte_data  <= 8'h00;
        end else begin
            link.byte_valid <= state_reg != TX_IDLE;
            link.byte_first <= state_reg == TX_ID;
            link.byte_last  <= state_reg == TX_SUM;
            case (state_reg)
                TX_ID:   link.byte_data <= lpcd_protect(id_reg);
                TX_DATA: link.byte_data <= cur_byte;
                TX_SUM:  link.byte_data <= ~sum_reg;
                default: link.byte_data <= 8'h00;
            endcase
        end
    end

    // Sent frame counter for status
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            frames_reg <= 8'h00;
        end else if (state_reg == TX_SUM) begin
            frames_reg <= frames_reg + 8'h01;
        end
    end

    // Address pins held high so short commands see the full low nibble
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            hardwired_address_pin_0_out <= 1'b1;
            hardwired_address_pin_1_out <= 1'b1;
            hardwired_address_pin_2_out <= 1'b1;
        end else begin
            hardwired_address_pin_0_out <= 1'b1;
            hardwired_address_pin_1_out <= 1'b1;
            hardwired_address_pin_2_out <= 1'b1;
        end
    end
endmodule // lpcd_master

// File: dv/lpcd_sva.sv
// Checker for the byte link and the node results
`timescale 1ns/1ps
module lpcd_sva (
    input wire logic        clock_in,
    input wire logic        rstn_in,
    input wire logic        byte_valid,
    input wire logic [7:0]  byte_data,
    input wire logic        byte_first,
    input wire logic        byte_last,
    input wire logic        target_valid_out,
    input wire logic [15:0] target_pos_out,
    input wire logic        target_halfstep_out,
    input wire logic        frame_dropped_out,
    input wire logic        cmd_refused_out,
    input wire logic [1:0]  microstep_resolution_in,
    input wire logic [1:0]  microstep_resolution_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // Identifier byte carries both parity bits
    property p_parity;
        byte_first |-> byte_valid && byte_data[6] == ^{byte_data[4], byte_data[2:0]}
            && byte_data[7] == !(^{byte_data[5:3], byte_data[1]});
    endproperty
    a_parity: assert property (p_parity) else $error("bad identifier parity");
    // Data count follows identifier bits 5:4, bytes back to back
    property p_len2;
        byte_first && !byte_data[5] |=> (byte_valid && !byte_last)[*2] ##1 byte_last;
    endproperty
    a_len2: assert property (p_len2) else $error("two byte frame length wrong");
    property p_len4;
        byte_first && byte_data[5:4] == 2'b10 |=> (byte_valid && !byte_last)[*4] ##1 byte_last;
    endproperty
    a_len4: assert property (p_len4) else $error("four byte frame length wrong");
    property p_len8;
        byte_first && byte_data[5:4] == 2'b11 |=> (byte_valid && !byte_last)[*8] ##1 byte_last;
    endproperty
    a_len8: assert property (p_len8) else $error("eight byte frame length wrong");
    // Any verdict comes one cycle after the checksum byte
    property p_verdict;
        target_valid_out || frame_dropped_out || cmd_refused_out |-> $past(byte_last);
    endproperty
    a_verdict: assert property (p_verdict) else $error("verdict out of step");
    // Target moves only with its valid pulse
    property p_hold;
        !target_valid_out && $past(rstn_in) |-> $stable(target_pos_out);
    endproperty
    a_hold: assert property (p_hold) else $error("target moved without pulse");
    property p_refuse;
        cmd_refused_out |-> !target_valid_out && $stable(target_pos_out);
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused command applied");
    // Short targets are sign extended from bit 10
    property p_sign;
        target_valid_out && target_halfstep_out |->
            target_pos_out[15:11] == {5{target_pos_out[10]}};
    endproperty
    a_sign: assert property (p_sign) else $error("short target not sign extended");
    property p_ustep;
        $past(rstn_in) |-> microstep_resolution_out == $past(microstep_resolution_in);
    endproperty
    a_ustep: assert property (p_ustep) else $error("resolution not passed on");
    c_short: cover property (target_valid_out && target_halfstep_out);
    c_full: cover property (target_valid_out && !target_halfstep_out);
    c_refused: cover property (cmd_refused_out);
endmodule // lpcd_sva

// File: dv/lpcd_tb.sv
// Testbench joining master and node ends over the byte link
`timescale 1ns/1ps
module lpcd_tb;
    import lpcd_pkg::*;
    logic        clock_in, rstn_in, psel, penable, pwrite, pready, pslverr, accept;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0]  hw;
    logic [6:0]  own_ad;
    logic [3:0]  own_sad, ptr;
    logic [5:0]  id_d, id_g, id_s1, id_s2, id_s4;
    logic [1:0]  ustep_in, ustep_out;
    logic        tvalid, thalf, dropped, refused;
    logic [15:0] tpos;
    logic [7:0]  frames;
    logic [17:0] exp_q[$];
    int          num_errors, compares;

    lpcd_link_if u_lpcd_link_if();
    lpcd_master u_lpcd_master (.clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .link(u_lpcd_link_if.master), .hardwired_address_pin_0_out(hw[0]),
        .hardwired_address_pin_1_out(hw[1]), .hardwired_address_pin_2_out(hw[2]));
    lpcd_node u_lpcd_node (.clock_in(clock_in), .rstn_in(rstn_in), .link(u_lpcd_link_if.node),
        .node_address_in(own_ad), .otp_node_address_bits_in(own_sad), .full_direct_id_in(id_d),
        .gp4_id_in(id_g), .gp4_pointer_in(ptr), .short1_id_in(id_s1), .short2_id_in(id_s2),
        .short4_id_in(id_s4), .accept_allowed_in(accept), .microstep_resolution_in(ustep_in),
        .target_valid_out(tvalid), .target_pos_out(tpos), .target_halfstep_out(thalf),
        .microstep_resolution_out(ustep_out), .frame_dropped_out(dropped),
        .cmd_refused_out(refused));
    lpcd_sva u_lpcd_sva (.clock_in(clock_in), .rstn_in(rstn_in),
        .byte_valid(u_lpcd_link_if.byte_valid), .byte_data(u_lpcd_link_if.byte_data),
        .byte_first(u_lpcd_link_if.byte_first), .byte_last(u_lpcd_link_if.byte_last),
        .target_valid_out(tvalid), .target_pos_out(tpos), .target_halfstep_out(thalf),
        .frame_dropped_out(dropped), .cmd_refused_out(refused),
        .microstep_resolution_in(ustep_in), .microstep_resolution_out(ustep_out));

    // 200 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic fail_out();
        num_errors++;
        conclude();
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; the request stands until pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Load a frame, start it, wait until idle; the note goes in before the go
    task automatic send(input logic [5:0] id, input logic [63:0] d, input logic [17:0] exp,
                        input bit want);
        logic [31:0] rd;
        logic err;
        int n;
        n = 0;
        if (want) exp_q.push_back(exp);
        apb(1'b1, REG_ID, {26'h0000000, id}, rd, err);
        apb(1'b1, REG_DATA_LO, d[31:0], rd, err);
        apb(1'b1, REG_DATA_HI, d[63:32], rd, err);
        apb(1'b1, REG_CTRL, 32'h00000001, rd, err);
        do begin
            apb(1'b0, REG_STATUS, 32'h00000000, rd, err);
            n++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 40);
        if (n >= 40) fail_out();
        frames++;
        check("frames sent", {24'h000000, rd[15:8]}, {24'h000000, frames});
        repeat (3) @(posedge clock_in);
    endtask

    function automatic logic [17:0] sh(input logic [10:0] v);
        return {2'b10, {5{v[10]}}, v};
    endfunction

    // Result watcher: every pulse takes the oldest note
    initial begin
        logic [17:0] seen;
        forever begin
            @(posedge clock_in);
            if (tvalid === 1'b1 || refused === 1'b1 || dropped === 1'b1) begin
                seen = tvalid ? {thalf ? 2'b10 : 2'b01, tpos} : {refused, refused, 16'h0000};
                if (exp_q.size() == 0) check("unasked result", {14'h0000, seen}, 32'hFFFFFFFF);
                else check("result", {14'h0000, seen}, {14'h0000, exp_q.pop_front()});
            end
        end
    end

    // Watchdog cuts a hang short
    initial begin
        repeat (60000) @(posedge clock_in);
        fail_out();
    end

    initial begin
        logic [15:0] p, q;
        logic [10:0] s, t;
        logic [31:0] rd;
        logic        err;
        {rstn_in, psel, penable, pwrite, paddr, pwdata, accept, ustep_in} = '0;
        {own_ad, own_sad, ptr, accept} = {7'h25, 4'h5, 4'h1, 1'b1};
        {id_d, id_g, id_s1, id_s2, id_s4} = {6'h05, 6'h21, 6'h07, 6'h22, 6'h33};
        {num_errors, compares, frames} = '0;
        repeat (10) @(posedge clock_in);
        rstn_in <= 1'b1;
        void'($urandom(32'hEB35));
        check("hardwired pins", {29'h00000000, hw}, 32'h00000007);
        check("reset target", {14'h0000, tvalid, thalf, tpos}, 32'h00000000);
        apb(1'b0, 12'h014, 32'h00000000, rd, err);
        check("unmapped error", {31'h00000000, err}, 32'h00000001);
        check("unmapped data", rd, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            {p, q, s, t} = 54'({$urandom, $urandom});
            ustep_in <= 2'($urandom);
            send(6'h05, {48'h0, p[7:0], p[15:8]}, {2'b01, p}, 1);
            send(6'h21, {32'h0, p[7:0], p[15:8], 8'hA5, 8'h8B}, {2'b01, p}, 1);
            send(6'h21, {32'h0, q[7:0], q[15:8], 8'h11, 8'h8B}, {2'b01, q}, 1);
            send(6'h21, {32'h0, p[7:0], p[15:8], 8'h91, 8'h8B}, 18'h0, 0);
            ptr <= 4'h0;
            send(6'h21, {32'h0, p[7:0], p[15:8], 8'hA5, 8'h8B}, 18'h0, 0);
            ptr <= 4'h1;
            send(6'h3C, {q[7:0], q[15:8], 8'h25, p[7:0], p[15:8], 8'h13, 8'h8B, 8'h80},
                 {2'b01, q}, 1);
            send(6'h3C, {q[7:0], q[15:8], 8'h13, p[7:0], p[15:8], 8'h25, 8'h8B, 8'h80},
                 {2'b01, p}, 1);
            send(6'h07, {48'h0, s[7:0], s[10:8], 5'h15}, sh(s), 1);
            send(6'h07, {48'h0, t[7:0], t[10:8], 5'h09}, sh(t), 1);
            send(6'h07, {48'h0, s[7:0], s[10:8], 5'h19}, 18'h0, 0);
            send(6'h22, {32'h0, s[7:0], s[10:8], 5'h15, t[7:0], t[10:8], 5'h13}, sh(s), 1);
            send(6'h22, {32'h0, s[7:0], s[10:8], 5'h05, t[7:0], t[10:8], 5'h13}, 18'h0, 0);
            send(6'h33, {s[7:0], s[10:8], 5'h15, t[7:0], t[10:8], 5'h19, t[7:0], t[10:8], 5'h17,
                 t[7:0], t[10:8], 5'h13}, sh(s), 1);
            accept <= 1'b0;
            send(6'h05, {48'h0, q[7:0], q[15:8]}, 18'h30000, 1);
            send(6'h07, {48'h0, t[7:0], t[10:8], 5'h15}, 18'h30000, 1);
            accept <= 1'b1;
        end
        repeat (10) @(posedge clock_in);
        check("notes left", exp_q.size(), 32'h00000000);
        conclude();
    end
endmodule // lpcd_tb
